// File: dv/smq_host_model.sv
// Host register file and status word model
`default_nettype none
module smq_host_model
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // From the multiply unit
   input wire logic reg_we,
   input wire logic [2:0] reg_waddr,
   input wire logic [15:0] reg_wdata,
   input wire logic psw_we,
   input wire logic [3:0] psw_flags,
   input wire logic bus_test,
   // Observed state
   output logic [15:0] regs [8],
   output logic [3:0] psw,
   output logic [3:0] bus_cnt
);
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         regs <= '{default: 16'h0000};
         {psw, bus_cnt} <= 8'h00;
      end
      else
      begin
         if (reg_we) regs[reg_waddr] <= reg_wdata;
         if (psw_we) psw <= psw_flags;
         if (bus_test) bus_cnt <= bus_cnt + 4'h1;
      end
endmodule // smq_host_model
`default_nettype wire

// File: dv/smq_multiply_chk.sv
// Port checker for the signed multiply sequencer
`default_nettype none
module smq_multiply_chk
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Request
   input wire logic start,
   input wire logic [15:0] dest_operand,
   input wire logic [15:0] source_reg,
   input wire logic [2:0] source_index,
   // Answer
   input wire logic reg_we,
   input wire logic [2:0] reg_waddr,
   input wire logic [15:0] reg_wdata,
   input wire logic busy,
   input wire logic done,
   input wire logic psw_we,
   input wire logic [3:0] psw_flags,
   input wire logic bus_test
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic [2:0] idx;
   logic first, both_mn, mn_neg;
   logic [4:0] cyc;
   wire take = start && !busy;
   // Remembers the accepted request and counts cycles since it
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         {idx, first, both_mn, mn_neg, cyc} <= '0;
      else if (take)
      begin
         {idx, first, cyc} <= {source_index, 1'b1, 5'h00};
         both_mn <= dest_operand == 16'h8000 && source_reg == 16'h8000;
         mn_neg <= dest_operand == 16'h8000 && source_reg[15];
      end
      else
      begin
         first <= first && !reg_we;
         cyc <= cyc + 5'(cyc != 5'h1F);
      end
   AST_TAKE: assert property (take |=> busy) else $error("start not taken");
   AST_HIGH: assert property (reg_we && first |-> reg_waddr == idx)
      else $error("high write address wrong");
   AST_LOW: assert property (reg_we && !first |-> reg_waddr == {idx[2:1], 1'b1})
      else $error("low write address wrong");
   AST_SKIP: assert property (both_mn && reg_we && !first |-> reg_wdata == 16'h0000)
      else $error("low product not zero");
   AST_LOOP: assert property (done && !both_mn |-> cyc >= 5'h12)
      else $error("loop too short");
   AST_V: assert property (psw_we |-> !psw_flags[1]) else $error("overflow set");
   AST_PSW: assert property (done |-> psw_we) else $error("status not moved");
   AST_ONE: assert property (done |=> !done) else $error("done held");
   AST_BUS: assert property (bus_test |-> mn_neg) else $error("stray bus test");
endmodule // smq_multiply_chk
bind smq_multiply smq_multiply_chk smq_multiply_chk_i (.mclk(mclk), .rst(rst),
   .start(start), .dest_operand(dest_operand), .source_reg(source_reg),
   .source_index(source_index), .reg_we(reg_we), .reg_waddr(reg_waddr),
   .reg_wdata(reg_wdata), .busy(busy), .done(done), .psw_we(psw_we),
   .psw_flags(psw_flags), .bus_test(bus_test));
`default_nettype wire

// File: dv/smq_multiply_test.sv
// Self-checking bench for the signed multiply sequencer
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
   $display("Error %s expected %h seen %h", n, e, s); end end
module smq_multiply_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [15:0] a, b; logic [2:0] idx; logic [31:0] p;} smq_row_t;
   logic mclk = 0, rst = 1, start = 0;
   logic [15:0] dest_operand = 16'h0000, source_reg = 16'h0000, reg_wdata;
   logic [15:0] regs [8];
   logic [2:0] source_index = 3'h0, reg_waddr;
   logic reg_we, busy, done, psw_we, bus_test;
   logic [3:0] local_flags, psw_flags, psw, bus_cnt, bexp = 4'h0;
   int checked = 0, miscompares = 0, cycles = 0;
   smq_row_t rows [10] = '{'{16'h0003, 16'h0005, 3'h0, 32'h0000000F},
      '{16'hFFFD, 16'h0005, 3'h2, 32'hFFFFFFF1}, '{16'h7FFF, 16'h7FFF, 3'h4, 32'h3FFF0001},
      '{16'h8000, 16'h7FFF, 3'h6, 32'hC0008000}, '{16'h8000, 16'hFFFF, 3'h0, 32'h00008000},
      '{16'h8000, 16'h8000, 3'h2, 32'h40000000}, '{16'h0000, 16'h1234, 3'h4, 32'h00000000},
      '{16'h0001, 16'hFFFF, 3'h5, 32'hFFFFFFFF}, '{16'hFFFF, 16'hFFFF, 3'h1, 32'h00000001},
      '{16'h1234, 16'h8000, 3'h3, 32'hF6E60000}};
   always #4 mclk = ~mclk;
   smq_multiply smq_multiply_i (.mclk(mclk), .rst(rst), .start(start),
      .dest_operand(dest_operand), .source_reg(source_reg), .source_index(source_index),
      .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .busy(busy),
      .done(done), .local_flags(local_flags), .psw_we(psw_we), .psw_flags(psw_flags),
      .bus_test(bus_test));
   smq_host_model smq_host_model_i (.mclk(mclk), .rst(rst), .reg_we(reg_we),
      .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .psw_we(psw_we),
      .psw_flags(psw_flags), .bus_test(bus_test), .regs(regs), .psw(psw), .bus_cnt(bus_cnt));
   task automatic wrap_up();
      $display("Checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One multiply; poke sends a second start while busy, which must be ignored
   task automatic run(input smq_row_t r, input bit poke);
      logic [15:0] hi, lo;
      logic [3:0] f;
      {hi, lo} = r.p;
      f = {hi[15], r.p == 32'h0, 1'b0, !(hi == {16{lo[15]}})};
      bexp += 4'(r.a == 16'h8000 && r.b[15]);
      @(posedge mclk) #1 {dest_operand, source_reg, source_index, start} = {r.a, r.b, r.idx, 1'b1};
      @(posedge mclk) #1 start = 0;
      repeat (3) @(posedge mclk);
      #1 {dest_operand, source_reg, start} = {16'h1111, 16'h2222, poke};
      @(posedge mclk) #1 start = 0;
      for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge mclk);
      @(negedge mclk);
      `CHK("high", r.idx[0] ? lo : hi, regs[r.idx])
      `CHK("low", lo, regs[r.idx | 3'h1])
      `CHK("flags", f, local_flags)
      `CHK("psw", f, psw)
      `CHK("bus", bexp, bus_cnt)
      $display("Test %h x %h done", r.a, r.b);
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (12) @(posedge mclk);
      #1 rst = 0;
      `CHK("busy", 1'b0, busy)
      `CHK("flags", 4'h0, local_flags)
      foreach (rows[i]) run(rows[i], i == 3);
      // Reset in mid-run, then a clean multiply
      @(posedge mclk) #1 {dest_operand, start} = {16'h0007, 1'b1};
      @(posedge mclk) #1 start = 0;
      repeat (5) @(posedge mclk);
      #1 rst = 1;
      @(posedge mclk) #1 rst = 0;
      bexp = 4'h0;
      `CHK("busy", 1'b0, busy)
      run(rows[0], 0);
      wrap_up();
   end
endmodule // smq_multiply_test
`default_nettype wire

// File: logic/smq_multiply.sv
// Sequenced signed 16x16 multiply unit
//
// Contract
// (RL1) Multiplier from destination, copied before start
// (RL2) Odd source: low product overwrites high
// (RL3) Complement multiplier, clear carry; test only
// (RL4) Most negative multiplier swaps in, clears upper
// (RL5) Check multiplicand most negative by subtraction
// (RL6) Both most negative: skip, shifted high, zero low
// (RL7) Add, subtract or pass, then shift right
// (RL8) Sixteen passes, counter decrements to zero
// (RL9) Positive path decrements counter once extra
// (RL10) High to even register, low to odd
// (RL11) Carry set when product exceeds one word
// (RL12) Fits when upper is sign extension of low
// (RL13) Overflow flag always cleared
// (RL14) Negative when below zero; zero when all zero
// (RL15) Copy flags to status word, return control
// (RL16) Counter-zero test pulses host request clocks
// (RL17) Multiplicand from source; 32-bit product pair
// (RL18) Booth recoding gives exact signed product
`include "smq_regs.svh"
`default_nettype none
module smq_multiply
   import smq_pkg::*;
#(
   parameter int WIDTH = `SMQ_WIDTH,
   parameter int REG_ADDR_W = 3
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Start request from the host microcontrol
   input wire logic start,
   input wire logic [WIDTH-1:0] dest_operand,
   input wire logic [WIDTH-1:0] source_reg,
   input wire logic [REG_ADDR_W-1:0] source_index,
   // Register file write port
   output logic reg_we,
   output logic [REG_ADDR_W-1:0] reg_waddr,
   output logic [WIDTH-1:0] reg_wdata,
   // Status and control back to the host
   output logic busy,
   output logic done,
   output logic [3:0] local_flags,
   output logic psw_we,
   output logic [3:0] psw_flags,
   output logic bus_test
);

   initial
   begin
      if (WIDTH != `SMQ_WIDTH)
         $error("smq_multiply supports only a 16-bit datapath");
      if (REG_ADDR_W < 1)
         $error("smq_multiply needs at least one register address bit");
   end

   function automatic logic [WIDTH-1:0] twos(input logic [WIDTH-1:0] v);
      twos = WIDTH'(~v + 1'b1);
   endfunction

   smq_state_t state;
   smq_state_t next_state;
   logic [WIDTH-1:0] upper_accumulator;
   logic [WIDTH-1:0] lower_accumulator;
   logic [WIDTH-1:0] operand_hold;
   logic [WIDTH-1:0] dest_copy;
   logic [WIDTH-1:0] multiplicand;
   logic [WIDTH-1:0] comp_mult;
   logic [REG_ADDR_W-1:0] src_idx;
   logic [4:0] pass_count;
   logic carry_bit;

   // Booth step on the 17-bit accumulator so the shift keeps the true sign
   wire [1:0] booth_sel = {lower_accumulator[0], carry_bit};
   wire [WIDTH:0] acc_ext = {upper_accumulator[WIDTH-1], upper_accumulator};
   wire [WIDTH:0] opd_ext = {operand_hold[WIDTH-1], operand_hold};
   wire [WIDTH:0] acc_add = acc_ext + opd_ext;
   wire [WIDTH:0] acc_sub = acc_ext - opd_ext;
   wire [WIDTH:0] result_selector = (booth_sel == 2'b10) ? acc_sub :
                                    (booth_sel == 2'b01) ? acc_add : acc_ext;
   wire [WIDTH-1:0] step_upper = result_selector[WIDTH:1];
   wire [WIDTH-1:0] step_lower = {result_selector[0], lower_accumulator[WIDTH-1:1]};
   wire step_carry = lower_accumulator[0];
   wire [WIDTH-1:0] mn_diff = WIDTH'(`SMQ_MOST_NEG - multiplicand);
   wire mcand_mneg = (mn_diff == `SMQ_ZERO16);
   wire [REG_ADDR_W-1:0] odd_idx = {src_idx[REG_ADDR_W-1:1], 1'b1};
   wire mult_neg = dest_copy[`SMQ_SIGN];
   wire mult_mneg = comp_mult[`SMQ_SIGN];
   wire mcand_neg = multiplicand[`SMQ_SIGN];
   // Multiplicand is only checked when the multiplier is most negative
   wire check_mcand = mult_mneg && mcand_neg;
   wire both_mneg = mcand_neg && mcand_mneg;
   wire last_pass = (pass_count == `SMQ_LAST_PASS);
   wire [4:0] count_dec = 5'(pass_count - `SMQ_COUNT_STEP);
   wire write_high = (state == SMQ_HIGH);
   wire write_low = (state == SMQ_LOW);
   // Odd source: high goes to the source itself, low then overlays it
   wire [REG_ADDR_W-1:0] next_waddr = write_low ? odd_idx : src_idx;
   wire [WIDTH-1:0] next_wdata = write_low ? lower_accumulator : upper_accumulator;
   wire [3:0] next_flags = {prod_neg, prod_zero, 1'b0, !fits_word};
   wire fits_word = (upper_accumulator == `SMQ_ALL_ONES && lower_accumulator[`SMQ_SIGN]) ||
                    (upper_accumulator == `SMQ_ZERO16 && !lower_accumulator[`SMQ_SIGN]);
   wire prod_zero = (upper_accumulator == `SMQ_ZERO16) && (lower_accumulator == `SMQ_ZERO16);
   wire prod_neg = upper_accumulator[`SMQ_SIGN];

   always_comb
   begin
      next_state = state;
      unique case (state)
         SMQ_IDLE:
         begin
            if (start)
            begin
               next_state = SMQ_LOAD;
            end
         end
         SMQ_LOAD:
         begin
            next_state = SMQ_COMP;
         end
         SMQ_COMP:
         begin
            if (mult_neg)
            begin
               next_state = SMQ_MNEG;
            end
            else
            begin
               next_state = SMQ_POS;
            end
         end
         SMQ_MNEG:
         begin
            if (check_mcand)
            begin
               next_state = SMQ_MNCK;
            end
            else
            begin
               next_state = SMQ_LOOP;
            end
         end
         SMQ_MNCK:
         begin
            if (both_mneg) // RL6
            begin
               next_state = SMQ_HIGH;
            end
            else
            begin
               next_state = SMQ_LOOP;
            end
         end
         SMQ_POS:
         begin
            next_state = SMQ_LOOP;
         end
         SMQ_LOOP:
         begin
            if (last_pass) // RL8
            begin
               next_state = SMQ_HIGH;
            end
         end
         SMQ_HIGH:
         begin
            next_state = SMQ_LOW;
         end
         SMQ_LOW:
         begin
            next_state = SMQ_FLAGS;
         end
         SMQ_FLAGS:
         begin
            next_state = SMQ_DONE;
         end
         SMQ_DONE:
         begin
            next_state = SMQ_IDLE;
         end
         default:
         begin
            next_state = SMQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
         state <= SMQ_IDLE;
      else
         state <= next_state;

   // Operand capture and arithmetic
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         upper_accumulator <= '0;
         lower_accumulator <= '0;
         operand_hold <= '0;
         dest_copy <= '0;
         multiplicand <= '0;
         comp_mult <= '0;
         src_idx <= '0;
         pass_count <= '0;
         carry_bit <= 1'b0;
      end
      else
      begin
         unique case (state)
            SMQ_IDLE:
               if (start)
               begin
                  upper_accumulator <= dest_operand; // RL1
                  operand_hold <= dest_operand; // RL1
                  dest_copy <= dest_operand; // RL1
                  multiplicand <= source_reg; // RL17
                  src_idx <= source_index;
               end
            SMQ_LOAD:
            begin
               comp_mult <= twos(dest_copy); // RL3
               carry_bit <= 1'b0; // RL3
               pass_count <= `SMQ_LOAD_COUNT;
            end
            SMQ_COMP:
            begin
               lower_accumulator <= dest_copy; // RL1
               operand_hold <= multiplicand; // RL18
               upper_accumulator <= '0;
            end
            SMQ_MNEG:
            begin
               // Most negative multiplier takes the multiplicand's place
               if (mult_mneg)
               begin
                  lower_accumulator <= multiplicand; // RL4
                  operand_hold <= dest_copy; // RL4
                  upper_accumulator <= '0; // RL4
               end
               if (!check_mcand)
               begin
                  pass_count <= count_dec;
               end
            end
            SMQ_MNCK:
            begin
               if (both_mneg) // RL5
               begin
                  upper_accumulator <= (`SMQ_MOST_NEG >> 1); // RL6
                  lower_accumulator <= '0; // RL6
               end
               else
               begin
                  pass_count <= count_dec;
               end
            end
            SMQ_POS:
            begin
               pass_count <= count_dec; // RL9
            end
            SMQ_LOOP:
            begin
               upper_accumulator <= step_upper; // RL7
               lower_accumulator <= step_lower; // RL7
               carry_bit <= step_carry; // RL18
               pass_count <= count_dec; // RL8
            end
            default:
            begin
            end
         endcase
      end
   end

   // Register file write strobe
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         reg_we <= 1'b0;
      end
      else
      begin
         reg_we <= write_high || write_low; // RL10
      end
   end

   // Write address and data hold between writes
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         reg_waddr <= '0;
         reg_wdata <= '0;
      end
      else if (write_high || write_low)
      begin
         reg_waddr <= next_waddr; // RL2 RL10
         reg_wdata <= next_wdata; // RL10
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         busy <= 1'b0;
      end
      else
      begin
         busy <= (state != SMQ_IDLE) || start;
      end
   end

   // Counter-zero test only on the most negative multiplicand check
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         bus_test <= 1'b0;
      end
      else
      begin
         bus_test <= (state == SMQ_MNCK); // RL16
      end
   end

   // Flags stand until the next multiply reaches this point
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         local_flags <= '0;
      end
      else if (state == SMQ_FLAGS)
      begin
         local_flags[`SMQ_FLAG_N] <= next_flags[`SMQ_FLAG_N]; // RL14
         local_flags[`SMQ_FLAG_Z] <= next_flags[`SMQ_FLAG_Z]; // RL14
         local_flags[`SMQ_FLAG_V] <= next_flags[`SMQ_FLAG_V]; // RL13
         local_flags[`SMQ_FLAG_C] <= next_flags[`SMQ_FLAG_C]; // RL11 RL12
      end
   end

   // Status word transfer and hand-back to the host
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         psw_we <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         psw_we <= (state == SMQ_DONE); // RL15
         done <= (state == SMQ_DONE); // RL15
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         psw_flags <= '0;
      end
      else if (state == SMQ_DONE)
      begin
         psw_flags <= local_flags; // RL15
      end
   end

endmodule // smq_multiply
`default_nettype wire

// File: shared/smq_pkg.sv
// Types for the signed multiply sequencer
`default_nettype none
package smq_pkg;
   typedef enum logic [3:0] {
      SMQ_IDLE = 4'b0000,
      SMQ_LOAD = 4'b0001,
      SMQ_COMP = 4'b0010,
      SMQ_MNEG = 4'b0011,
      SMQ_MNCK = 4'b0100,
      SMQ_POS = 4'b0101,
      SMQ_LOOP = 4'b0110,
      SMQ_HIGH = 4'b0111,
      SMQ_LOW = 4'b1000,
      SMQ_FLAGS = 4'b1001,
      SMQ_DONE = 4'b1010
   } smq_state_t;
endpackage
`default_nettype wire

// File: shared/smq_regs.svh
// Constants for the signed multiply sequencer
`ifndef SMQ_REGS_SVH
`define SMQ_REGS_SVH
`define SMQ_WIDTH 16
`define SMQ_PASSES 5'h10
// One pass more than the loop runs; every path into the loop spends it before the loop
`define SMQ_LOAD_COUNT 5'h11
`define SMQ_LAST_PASS 5'h01
`define SMQ_COUNT_STEP 5'h01
`define SMQ_MOST_NEG 16'h8000
`define SMQ_ALL_ONES 16'hFFFF
`define SMQ_ZERO16 16'h0000
`define SMQ_SIGN 15
`define SMQ_ODD_BIT 0
`define SMQ_FLAG_N 3
`define SMQ_FLAG_Z 2
`define SMQ_FLAG_V 1
`define SMQ_FLAG_C 0
`endif
